// ==== testbench/cmd_master.sv ====
// Purpose: command word master facing the drive state machine
// Assumes: one-cycle write strobe per word
// Notes:   the released data bus shows the inverse of the last word
`timescale 1ns/1ps
module cmd_master (
    // clock
    input  wire logic        sys_clk,
    // command port
    output logic      [15:0] cmd_wdata,
    output logic             cmd_we
);
    initial begin
        cmd_wdata = 16'h0000;
        cmd_we    = 1'b0;
    end
    task automatic write(input logic [15:0] d);
        @(posedge sys_clk);
        cmd_wdata <= d;
        cmd_we    <= 1'b1;
        @(posedge sys_clk);
        cmd_we    <= 1'b0;
        cmd_wdata <= ~d;
    endtask
endmodule

// ==== testbench/drive_cmd_fsm_chk.sv ====
// Purpose: port-level checks for the drive command state machine
// Assumes: state word status bits are registered one cycle after their causes, the state code two cycles
// Notes:   bound to every drive_cmd_fsm instance
`timescale 1ns/1ps
module drive_cmd_fsm_chk #(
    parameter int     W                  = 16,
    parameter longint FAULT_BLOCK_CYCLES = 20
) (
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rst,
    // watched inputs
    input wire logic         cmd_we,
    input wire logic [1:0]   mode_select,
    input wire logic         release_input,
    input wire logic         fault_event,
    input wire logic         warning_flag,
    input wire logic         ref_reached_in,
    input wire logic         power_fail_zero_hz,
    input wire logic         limiter_active,
    // watched outputs
    input wire logic [W-1:0] drive_command_word,
    input wire logic [W-1:0] drive_state_word,
    input wire logic         output_stage_enable
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire [6:0] code = drive_state_word[6:0];
    ////////////////////////////////////////////////////////////////////////////
    reset_code_a: assert property ($fell(rst) |-> ##[1:2] code == 7'h40)
        else $error("state code after reset is not start inhibit");
    crit_warn_a: assert property (drive_state_word[15] |-> drive_state_word[7])
        else $error("critical warning shown without warning bit");
    warn_bit_a: assert property ($rose(warning_flag) |-> ##[1:2] drive_state_word[7])
        else $error("warning bit missing");
    limit_bit_a: assert property ((limiter_active)[*2] |-> drive_state_word[11])
        else $error("limit bit missing");
    ref_bit_a: assert property ((ref_reached_in || power_fail_zero_hz)[*2] |->
        drive_state_word[10]) else $error("reference reached bit missing");
    fault_code_a: assert property ($rose(fault_event) |->
        ##[1:3] (code == 7'h0f || code == 7'h08)) else $error("fault not entered");
    refused_write_a: assert property (cmd_we && mode_select != 2'h1 |=>
        $stable(drive_command_word)) else $error("write taken outside mode");
    release_off_a: assert property ((!release_input)[*4] |=> !output_stage_enable)
        else $error("output stage on without release");
    stage_state_a: assert property (output_stage_enable |=>
        code == 7'h27 || code == 7'h07) else $error("output stage on in wrong state");
    spare_bits_a: assert property (drive_state_word[14:12] == 3'h0
        && !drive_state_word[8]) else $error("unused state word bits set");
    remote_mode_a: assert property ((mode_select != 2'h1)[*3] |=>
        !drive_state_word[9]) else $error("remote bit set outside mode");
    run_c: cover property (code == 7'h27);
    qstop_c: cover property (code == 7'h07);
    fault_c: cover property (code == 7'h08);
endmodule

bind drive_cmd_fsm drive_cmd_fsm_chk #(
    .W                  (W),
    .FAULT_BLOCK_CYCLES (FAULT_BLOCK_CYCLES)
) chk_u (
    .sys_clk, .rst, .cmd_we, .mode_select, .release_input, .fault_event,
    .warning_flag, .ref_reached_in, .power_fail_zero_hz, .limiter_active,
    .drive_command_word, .drive_state_word, .output_stage_enable
);

// ==== testbench/drive_cmd_fsm_tb.sv ====
// Purpose: self-checking bench of the drive command state machine
// Assumes: fault block shortened to BLOCK cycles, hold time of 8 cycles
// Notes:   expected codes come from the transition table
`timescale 1ns/1ps
module drive_cmd_fsm_tb;
    localparam int BLOCK = 20;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] cmd_wdata;
    logic        cmd_we;
    logic        release_input = 1'b0, start_clockwise_input = 1'b0;
    logic        start_anticlockwise_input = 1'b0;
    logic [1:0]  mode_select = 2'h0, disable_behaviour = 2'h0;
    logic [31:0] hold_cycles = 32'h8;
    logic        fault_event = 1'b0, fault_reaction_done = 1'b0, warning_flag = 1'b0;
    logic        critical_warning_flag = 1'b0, ref_reached_in = 1'b0, brake_done = 1'b0;
    logic        power_fail_zero_hz = 1'b0, limiter_active = 1'b0, below_switch_off = 1'b0;
    logic [15:0] drive_command_word, drive_state_word;
    logic        output_stage_enable, coast_request, ramp_request, dc_brake_request;
    logic        quick_stop_ramp, quick_stop_anticlockwise;
    int          n_fail = 0, check_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    drive_cmd_fsm #(
        .FAULT_BLOCK_CYCLES (BLOCK)
    ) dut_u (
        .sys_clk, .rst, .cmd_wdata, .cmd_we, .release_input, .start_clockwise_input,
        .start_anticlockwise_input, .mode_select, .disable_behaviour, .hold_cycles,
        .fault_event, .fault_reaction_done, .warning_flag, .critical_warning_flag,
        .ref_reached_in, .power_fail_zero_hz, .limiter_active, .below_switch_off,
        .brake_done, .standstill (1'b0), .drive_command_word, .drive_state_word,
        .output_stage_enable, .coast_request, .ramp_request, .dc_brake_request,
        .quick_stop_ramp, .quick_stop_anticlockwise
    );
    cmd_master m_u (.sys_clk, .cmd_wdata, .cmd_we);
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic code(input logic [6:0] exp);
        chk({9'h0, drive_state_word[6:0]}, {9'h0, exp});
    endtask
    task automatic cmd(input logic [15:0] d, input logic [6:0] exp);
        m_u.write(d);
        wait_n(3);
        code(exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        release_input <= 1'b1;
        wait_n(3);
        code(7'h40);
        cmd(16'h000f, 7'h40);
        chk(drive_command_word, 16'h0000);
        @(posedge sys_clk);
        mode_select <= 2'h1;
        cmd(16'h000f, 7'h40);
        chk({15'h0, drive_state_word[9]}, 16'h0000);
        cmd(16'h0007, 7'h40);
        cmd(16'h0006, 7'h21);
        cmd(16'h0000, 7'h40);
        @(posedge sys_clk);
        start_clockwise_input <= 1'b1;
        wait_n(3);
        cmd(16'h000f, 7'h27);
        chk({15'h0, drive_state_word[9]}, 16'h0001);
        chk({15'h0, output_stage_enable}, 16'h0001);
        for (int b = 0; b < 3; b++) begin
            @(posedge sys_clk);
            disable_behaviour <= 2'(b);
            cmd(16'h0007, b == 0 ? 7'h23 : 7'h27);
            chk({14'h0, dc_brake_request, ramp_request}, {14'h0, b == 1, b == 2});
            @(posedge sys_clk);
            brake_done <= 1'b1;
            below_switch_off <= 1'b1;
            wait_n(14);
            code(7'h23);
            @(posedge sys_clk);
            brake_done <= 1'b0;
            below_switch_off <= 1'b0;
            cmd(16'h000f, 7'h27);
        end
        cmd(16'h0007, 7'h27);
        cmd(16'h000f, 7'h27);
        chk({15'h0, ramp_request}, 16'h0000);
        @(posedge sys_clk);
        start_clockwise_input <= 1'b0;
        start_anticlockwise_input <= 1'b1;
        wait_n(3);
        cmd(16'h0002, 7'h07);
        chk({14'h0, quick_stop_ramp, quick_stop_anticlockwise}, 16'h0003);
        @(posedge sys_clk);
        below_switch_off <= 1'b1;
        wait_n(4);
        code(7'h07);
        chk({15'h0, output_stage_enable}, 16'h0001);
        wait_n(10);
        code(7'h40);
        @(posedge sys_clk);
        below_switch_off <= 1'b0;
        cmd(16'h000f, 7'h27);
        @(posedge sys_clk);
        release_input <= 1'b0;
        wait_n(5);
        code(7'h23);
        chk({15'h0, coast_request}, 16'h0001);
        m_u.write(16'h0006);
        wait_n(2);
        chk(drive_command_word, 16'h000f);
        code(7'h23);
        @(posedge sys_clk);
        release_input <= 1'b1;
        critical_warning_flag <= 1'b1;
        limiter_active <= 1'b1;
        power_fail_zero_hz <= 1'b1;
        wait_n(4);
        chk(drive_state_word & 16'h8e80, 16'h8e80);
        @(posedge sys_clk);
        critical_warning_flag <= 1'b0;
        limiter_active <= 1'b0;
        power_fail_zero_hz <= 1'b0;
        warning_flag <= 1'b1;
        ref_reached_in <= 1'b1;
        wait_n(2);
        chk(drive_state_word & 16'h8e80, 16'h0680);
        @(posedge sys_clk);
        fault_event <= 1'b1;
        @(posedge sys_clk);
        fault_event <= 1'b0;
        wait_n(2);
        code(7'h0f);
        @(posedge sys_clk);
        fault_reaction_done <= 1'b1;
        wait_n(3);
        code(7'h08);
        m_u.write(16'h0000);
        cmd(16'h0080, 7'h08);
        wait_n(BLOCK);
        cmd(16'h0080, 7'h08);
        m_u.write(16'h0000);
        cmd(16'h0080, 7'h40);
        stop_test;
    end
endmodule

// ==== verilog/drive_cmd_fsm.sv ====
// Purpose: command word decoder and operating state machine of a drive
// Assumes: motor-side progress reported by plain inputs from the drive core
// Notes:   pins pass a two-stage synchroniser; drive core inputs are same-clock
`timescale 1ns/1ps
`include "drive_ctrl_defines.svh"

module drive_cmd_fsm #(
    parameter int          W                  = `WORD_W,
    parameter longint      FAULT_BLOCK_CYCLES = `FAULT_BLOCK_CYCLES,
    parameter int          HOLD_W             = 32
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // command word write port
    input  wire logic [W-1:0]  cmd_wdata,
    input  wire logic          cmd_we,
    // pins
    input  wire logic          release_input,
    input  wire logic          start_clockwise_input,
    input  wire logic          start_anticlockwise_input,
    // configuration
    input  wire logic [1:0]    mode_select,
    input  wire logic [1:0]    disable_behaviour,
    input  wire logic [HOLD_W-1:0] hold_cycles,
    // drive core status
    input  wire logic          fault_event,
    input  wire logic          fault_reaction_done,
    input  wire logic          warning_flag,
    input  wire logic          critical_warning_flag,
    input  wire logic          ref_reached_in,
    input  wire logic          power_fail_zero_hz,
    input  wire logic          limiter_active,
    input  wire logic          below_switch_off,
    input  wire logic          brake_done,
    input  wire logic          standstill,
    // outputs
    output logic [W-1:0]       drive_command_word,
    output logic [W-1:0]       drive_state_word,
    output logic               output_stage_enable,
    output logic               coast_request,
    output logic               ramp_request,
    output logic               dc_brake_request,
    output logic               quick_stop_ramp,
    output logic               quick_stop_anticlockwise
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pins_s;
    sync2 #(.W(3)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     ({release_input, start_clockwise_input, start_anticlockwise_input}),
        .dout    (pins_s)
    );
    wire rel_s   = pins_s[2];
    wire start_s = pins_s[1] | pins_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // registers and their next values
    drive_ctrl_pkg::drive_state_e state_q, state_d;
    logic [W-1:0]  cmd_q;
    logic          bit7_prev_q;
    logic [63:0]   block_cnt_q;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic          holding_q;
    logic          dir_ccw_q;
    logic          stopping_q;
    logic [W-1:0]  status_d;

    wire sm_mode   = (mode_select == `MODE_STATE_MACHINE);
    wire accept    = cmd_we & rel_s & sm_mode;
    wire [W-1:0] cmd_eff = accept ? cmd_wdata : cmd_q;
    wire remote    = sm_mode & rel_s & start_s;

    // command decodes on the effective word
    wire c_shutdown = cmd_eff[2] & cmd_eff[1] & ~cmd_eff[0];
    wire c_switchon = cmd_eff[2] & cmd_eff[1] & cmd_eff[0] & ~cmd_eff[3];
    wire c_voltoff  = ~cmd_eff[1];
    wire c_qstop    = ~cmd_eff[2] & cmd_eff[1];
    wire c_openable = cmd_eff[3] & cmd_eff[2] & cmd_eff[1] & cmd_eff[0];
    wire c_opdis    = c_switchon;
    wire rst_edge   = cmd_eff[`CMD_RESET_BIT] & ~bit7_prev_q;
    wire block_over = (block_cnt_q >= 64'(FAULT_BLOCK_CYCLES));
    wire enable_ok  = rel_s & start_s & c_openable;
    wire hold_done  = holding_q & (hold_cnt_q >= hold_cycles);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        if (fault_event && state_q != drive_ctrl_pkg::FAULT) begin
            state_d = drive_ctrl_pkg::FAULT_REACTION;
        end else if (!rel_s && (state_q == drive_ctrl_pkg::RUNNING ||
                                state_q == drive_ctrl_pkg::QUICK_STOP)) begin
            state_d = drive_ctrl_pkg::POWERED_IDLE;
        end else begin
            case (state_q)
                drive_ctrl_pkg::NOT_READY: begin
                    state_d = drive_ctrl_pkg::START_INHIBIT;
                end
                drive_ctrl_pkg::START_INHIBIT: begin
                    if (sm_mode && enable_ok) begin
                        state_d = drive_ctrl_pkg::RUNNING;
                    end else if (sm_mode && c_shutdown) begin
                        state_d = drive_ctrl_pkg::READY;
                    end
                end
                drive_ctrl_pkg::READY: begin
                    if (sm_mode && c_voltoff) begin
                        state_d = drive_ctrl_pkg::START_INHIBIT;
                    end else if (sm_mode && c_switchon) begin
                        state_d = drive_ctrl_pkg::POWERED_IDLE;
                    end
                end
                drive_ctrl_pkg::POWERED_IDLE: begin
                    if (sm_mode && enable_ok) begin
                        state_d = drive_ctrl_pkg::RUNNING;
                    end else if (sm_mode && c_shutdown) begin
                        state_d = drive_ctrl_pkg::READY;
                    end else if (sm_mode && c_voltoff) begin
                        state_d = drive_ctrl_pkg::START_INHIBIT;
                    end
                end
                drive_ctrl_pkg::RUNNING: begin
                    if (sm_mode && c_qstop) begin
                        state_d = drive_ctrl_pkg::QUICK_STOP;
                    end else if (sm_mode && c_voltoff) begin
                        state_d = drive_ctrl_pkg::START_INHIBIT;
                    end else if (sm_mode && c_shutdown) begin
                        state_d = drive_ctrl_pkg::READY;
                    end else if (stopping_q) begin
                        if (disable_behaviour == `DIS_DC_BRAKE && brake_done) begin
                            state_d = drive_ctrl_pkg::POWERED_IDLE;
                        end else if (disable_behaviour == `DIS_RAMP && hold_done) begin
                            state_d = drive_ctrl_pkg::POWERED_IDLE;
                        end
                    end else if (sm_mode && c_opdis &&
                                 disable_behaviour == `DIS_COAST) begin
                        state_d = drive_ctrl_pkg::POWERED_IDLE;
                    end
                end
                drive_ctrl_pkg::QUICK_STOP: begin
                    if (hold_done) begin
                        state_d = drive_ctrl_pkg::START_INHIBIT;
                    end
                end
                drive_ctrl_pkg::FAULT_REACTION: begin
                    if (fault_reaction_done) begin
                        state_d = drive_ctrl_pkg::FAULT;
                    end
                end
                drive_ctrl_pkg::FAULT: begin
                    if (sm_mode && rst_edge && block_over) begin
                        state_d = drive_ctrl_pkg::START_INHIBIT;
                    end
                end
                default: begin
                    state_d = drive_ctrl_pkg::START_INHIBIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word
    always_comb begin
        status_d                    = '0;
        status_d[6:0]               = state_q;
        status_d[`BIT_WARNING]      = warning_flag | critical_warning_flag;
        status_d[`BIT_REMOTE]       = remote;
        status_d[`BIT_REF_REACHED]  = ref_reached_in | power_fail_zero_hz;
        status_d[`BIT_LIMIT]        = limiter_active;
        status_d[`BIT_CRIT_WARNING] = critical_warning_flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state, command and timers
    wire entering_fault = (state_d == drive_ctrl_pkg::FAULT_REACTION) &&
                          (state_q != drive_ctrl_pkg::FAULT_REACTION);
    wire in_stop = (state_q == drive_ctrl_pkg::QUICK_STOP) ||
                   (stopping_q && disable_behaviour == `DIS_RAMP);
    wire start_stop = (state_q == drive_ctrl_pkg::RUNNING) && sm_mode && c_opdis &&
                      (disable_behaviour != `DIS_COAST);
    wire resume = stopping_q && sm_mode && c_openable &&
                  (disable_behaviour == `DIS_RAMP);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q     <= drive_ctrl_pkg::START_INHIBIT;
            cmd_q       <= '0;
            bit7_prev_q <= 1'b0;
            block_cnt_q <= '0;
            hold_cnt_q  <= '0;
            holding_q   <= 1'b0;
            stopping_q  <= 1'b0;
            dir_ccw_q   <= 1'b0;
        end else begin
            state_q     <= state_d;
            cmd_q       <= cmd_eff;
            bit7_prev_q <= cmd_eff[`CMD_RESET_BIT];
            if (entering_fault) begin
                block_cnt_q <= '0;
            end else if (!block_over) begin
                block_cnt_q <= block_cnt_q + 64'd1;
            end
            if (state_d != drive_ctrl_pkg::RUNNING || resume) begin
                stopping_q <= 1'b0;
            end else if (start_stop) begin
                stopping_q <= 1'b1;
            end
            if (!in_stop || state_d != state_q) begin
                holding_q  <= 1'b0;
                hold_cnt_q <= '0;
            end else if (below_switch_off || holding_q) begin
                holding_q  <= 1'b1;
                hold_cnt_q <= hold_cnt_q + HOLD_W'(1);
            end
            if (state_q == drive_ctrl_pkg::RUNNING && !stopping_q && !c_qstop) begin
                dir_ccw_q <= pins_s[0] & ~pins_s[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drive_command_word       <= '0;
            drive_state_word         <= '0;
            output_stage_enable      <= 1'b0;
            coast_request            <= 1'b0;
            ramp_request             <= 1'b0;
            dc_brake_request         <= 1'b0;
            quick_stop_ramp          <= 1'b0;
            quick_stop_anticlockwise <= 1'b0;
        end else begin
            drive_command_word  <= cmd_eff;
            drive_state_word    <= status_d;
            // current stays on through the hold window
            output_stage_enable <= (state_d == drive_ctrl_pkg::RUNNING) ||
                                   (state_d == drive_ctrl_pkg::QUICK_STOP);
            coast_request       <= !rel_s;
            ramp_request        <= stopping_q && disable_behaviour == `DIS_RAMP;
            dc_brake_request    <= stopping_q && disable_behaviour == `DIS_DC_BRAKE;
            quick_stop_ramp     <= (state_d == drive_ctrl_pkg::QUICK_STOP);
            quick_stop_anticlockwise <= dir_ccw_q;
        end
    end
endmodule

// ==== verilog/drive_ctrl_defines.svh ====
// Purpose: offsets-free constants for the drive command state machine
// Assumes: sys_clk at 200 MHz
// Notes:   status codes occupy bits 6..0 of the state word
`ifndef DRIVE_CTRL_DEFINES_SVH
`define DRIVE_CTRL_DEFINES_SVH

`define WORD_W              16
`define MODE_STATE_MACHINE  2'd1
`define ST_NOT_READY        7'h00
`define ST_START_INHIBIT    7'h40
`define ST_READY            7'h21
`define ST_QUICK_STOP       7'h07
`define ST_POWERED_IDLE     7'h23
`define ST_RUNNING          7'h27
`define ST_FAULT            7'h08
`define ST_FAULT_REACTION   7'h0f
`define BIT_WARNING         7
`define BIT_REMOTE          9
`define BIT_REF_REACHED     10
`define BIT_LIMIT           11
`define BIT_CRIT_WARNING    15
`define CMD_RESET_BIT       7
`define DIS_COAST           2'd0
`define DIS_DC_BRAKE        2'd1
`define DIS_RAMP            2'd2
`define FAULT_BLOCK_S       15
`define CLK_HZ              200000000
`define FAULT_BLOCK_CYCLES  (64'(`FAULT_BLOCK_S) * 64'(`CLK_HZ))

`endif

// ==== verilog/drive_ctrl_pkg.sv ====
// Purpose: types for the drive command state machine
// Assumes: nothing
// Notes:   state codes equal the reported status code
package drive_ctrl_pkg;
    typedef enum logic [6:0] {
        NOT_READY      = 7'b0000000,
        START_INHIBIT  = 7'b1000000,
        READY          = 7'b0100001,
        QUICK_STOP     = 7'b0000111,
        POWERED_IDLE   = 7'b0100011,
        RUNNING        = 7'b0100111,
        FAULT          = 7'b0001000,
        FAULT_REACTION = 7'b0001111
    } drive_state_e;
endpackage

// ==== verilog/sync2.sv ====
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: inputs are static relative to sys_clk settling
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
